//--- aic_pkg.sv
// Purpose: Shared constants and types for the amplifier control slave
// Assumes: 100 MHz system clock, AXI4-Lite with 32-bit data
// Notes:   Register indices are word indices; bus byte address is four times
package aic_pkg;

    // Serial slave address and register indices
    localparam logic [6:0] AIC_SLAVE_ADDR = 7'h6C;
    localparam logic [7:0] AIC_IDX_FAULT  = 8'h01;
    localparam logic [7:0] AIC_IDX_STATUS = 8'h02;
    localparam logic [7:0] AIC_IDX_CTRL   = 8'h03;

    // Bus byte addresses derived from the indices
    localparam int         AIC_AXI_AW      = 8;
    localparam logic [7:0] AIC_AXI_FAULT   = {AIC_IDX_FAULT[5:0], 2'b00};
    localparam logic [7:0] AIC_AXI_STATUS  = {AIC_IDX_STATUS[5:0], 2'b00};
    localparam logic [7:0] AIC_AXI_CTRL    = {AIC_IDX_CTRL[5:0], 2'b00};

    // Control register reset and fields
    localparam logic [7:0] AIC_CTRL_RESET  = 8'h78;
    localparam int         AIC_CTRL_GAIN_HI = 7;
    localparam int         AIC_CTRL_GAIN_LO = 6;
    localparam int         AIC_CTRL_LIM_HI  = 5;
    localparam int         AIC_CTRL_LIM_LO  = 3;
    localparam int         AIC_CTRL_FREQ    = 0;

    // Fault register bit positions
    localparam int AIC_FLT_OVERHEAT = 7;
    localparam int AIC_FLT_DC       = 6;
    localparam int AIC_FLT_HIGH     = 5;
    localparam int AIC_FLT_LOW      = 4;
    localparam int AIC_FLT_OVERCUR  = 3;
    localparam int AIC_FLT_DIAG     = 2;

    // Status register bit positions
    localparam int AIC_ST_PLAY  = 7;
    localparam int AIC_ST_MUTE  = 6;
    localparam int AIC_ST_DIAG  = 5;
    localparam int AIC_ST_FAULT = 4;

    // AXI responses
    localparam logic [1:0] AIC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AIC_RESP_SLVERR = 2'h2;

    // Wake time after shutdown release, least time rounded up
    localparam int AIC_CLK_NS    = 10;
    localparam int AIC_WAKE_NS   = 1000000;
    localparam int AIC_WAKE_CYC  = (AIC_WAKE_NS + AIC_CLK_NS - 1) / AIC_CLK_NS;
    localparam int AIC_WAKE_W    = 17;

    // Monitor inputs from the analogue protection and diagnostic blocks
    typedef struct packed {
        logic die_overheat_shutdown;
        logic output_overcurrent;
        logic supply_low;
        logic supply_high;
        logic dc_offset;
        logic diag_running;
        logic diag_done;
        logic short_power_stage_supply;
        logic short_ground;
        logic open_load;
        logic shorted_load;
    } aic_mon_s;

    // Settings and mode sent to the power stage
    typedef struct packed {
        logic [1:0] gain;
        logic [2:0] limit;
        logic       freq_500k;
        logic       play;
        logic       outputs_hiz;
    } aic_amp_s;

    typedef enum logic [2:0] {
        AIC_IDLE,
        AIC_RX,
        AIC_ACK,
        AIC_TX,
        AIC_MACK,
        AIC_IGNORE
    } aic_i2c_e;

    typedef enum logic [1:0] {
        AIC_K_ADDR,
        AIC_K_INDEX,
        AIC_K_DATA
    } aic_kind_e;

endpackage : aic_pkg

//--- aic_ctrl_slave.sv
// Purpose: Serial control slave, pin mode control and AXI4-Lite view
// Assumes: scl, sda, pins and monitors are asynchronous, two flops each
// Notes:   Serial side never stretches the clock; sda and alarm open drain
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
module aic_ctrl_slave
    import aic_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = AIC_WAKE_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    input  wire logic                  standby_n,
    input  wire logic                  silence,
    output logic                       alarm_n_out,
    output logic                       alarm_n_oe,
    input  wire aic_mon_s              monitor,
    output aic_amp_s                   amp,
    input  wire logic [AIC_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [AIC_AXI_AW-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);

    typedef struct packed {
        logic                  scl_m;
        logic                  scl_s;
        logic                  scl_d;
        logic                  sda_m;
        logic                  sda_s;
        logic                  sda_d;
        logic                  stby_m;
        logic                  stby_s;
        logic                  sil_m;
        logic                  sil_s;
        aic_mon_s              mon_m;
        aic_mon_s              mon_s;
        logic                  ready;
        logic [AIC_WAKE_W-1:0] wake_cnt;
        aic_i2c_e              i2c_st;
        aic_kind_e             kind;
        logic [3:0]            cnt;
        logic [7:0]            sh;
        logic [7:0]            idx;
        logic                  rw;
        logic                  mack;
        logic                  sda_oe;
        logic [7:0]            fault;
        logic [3:0]            diag;
        logic [7:0]            ctrl;
        logic                  alarm_oe;
        aic_amp_s              amp;
        logic                  awready;
        logic                  wready;
        logic                  aw_got;
        logic                  w_got;
        logic [AIC_AXI_AW-1:0] awaddr;
        logic [7:0]            wdata;
        logic                  wstrb0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } aic_st_s;

    aic_st_s    s_r;
    aic_st_s    s_nxt;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic [7:0] live_flt;
    logic [7:0] status;

    // Register read mux shared by serial and AXI sides
    function automatic logic [7:0] aic_rd(input logic [7:0] idx,
                                          input logic [7:0] flt,
                                          input logic [7:0] sts,
                                          input logic [7:0] ctl);
        logic [7:0] v;
        v = 8'h00;
        if (idx == AIC_IDX_FAULT) begin
            v = flt;
        end else if (idx == AIC_IDX_STATUS) begin
            v = sts;
        end else if (idx == AIC_IDX_CTRL) begin
            v = ctl;
        end
        return v;
    endfunction : aic_rd

    // AXI byte address to register index, zero when unmapped
    function automatic logic [7:0] aic_axi_idx(input logic [AIC_AXI_AW-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == AIC_AXI_FAULT) begin
            v = AIC_IDX_FAULT;
        end else if (a == AIC_AXI_STATUS) begin
            v = AIC_IDX_STATUS;
        end else if (a == AIC_AXI_CTRL) begin
            v = AIC_IDX_CTRL;
        end
        return v;
    endfunction : aic_axi_idx

    // Bus edges and conditions from synchronised samples
    assign scl_rise  = s_r.scl_s & ~s_r.scl_d;
    assign scl_fall  = ~s_r.scl_s & s_r.scl_d;
    assign bus_start = s_r.scl_s & s_r.scl_d & s_r.sda_d & ~s_r.sda_s;
    assign bus_stop  = s_r.scl_s & s_r.scl_d & ~s_r.sda_d & s_r.sda_s;

    // Live faults that force the outputs to Hi-Z
    always_comb begin
        live_flt = 8'h00;
        live_flt[AIC_FLT_OVERHEAT] = s_r.mon_s.die_overheat_shutdown;
        live_flt[AIC_FLT_DC]       = s_r.mon_s.dc_offset;
        live_flt[AIC_FLT_HIGH]     = s_r.mon_s.supply_high;
        live_flt[AIC_FLT_LOW]      = s_r.mon_s.supply_low;
        live_flt[AIC_FLT_OVERCUR]  = s_r.mon_s.output_overcurrent;
        live_flt[AIC_FLT_DIAG]     = s_r.mon_s.short_power_stage_supply
                                   | s_r.mon_s.short_ground
                                   | s_r.mon_s.shorted_load;
    end

    // Status register view
    always_comb begin
        status = {4'h0, s_r.diag};
        status[AIC_ST_PLAY]  = s_r.amp.play;
        status[AIC_ST_MUTE]  = s_r.sil_s;
        status[AIC_ST_DIAG]  = s_r.mon_s.diag_running;
        status[AIC_ST_FAULT] = |live_flt;
    end

    // Next state of the whole block
    always_comb begin
        logic clr;
        logic [7:0] nidx;
        clr  = 1'b0;
        nidx = 8'h00;
        s_nxt = s_r;
        // Two-flop synchronisers
        s_nxt.scl_m  = scl_in;
        s_nxt.scl_s  = s_r.scl_m;
        s_nxt.scl_d  = s_r.scl_s;
        s_nxt.sda_m  = sda_in;
        s_nxt.sda_s  = s_r.sda_m;
        s_nxt.sda_d  = s_r.sda_s;
        s_nxt.stby_m = standby_n;
        s_nxt.stby_s = s_r.stby_m;
        s_nxt.sil_m  = silence;
        s_nxt.sil_s  = s_r.sil_m;
        s_nxt.mon_m  = monitor;
        s_nxt.mon_s  = s_r.mon_m;

        // AXI write channels, either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.awaddr  = s_axi_awaddr;
            s_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.wdata  = s_axi_wdata[7:0];
            s_nxt.wstrb0 = s_axi_wstrb[0];
            s_nxt.wready = 1'b0;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = AIC_RESP_OKAY;
            if (aic_axi_idx(s_r.awaddr) == 8'h00) begin
                s_nxt.bresp = AIC_RESP_SLVERR;
            end else if (aic_axi_idx(s_r.awaddr) == AIC_IDX_CTRL && s_r.wstrb0
                         && s_r.stby_s) begin
                s_nxt.ctrl = s_r.wdata;
            end
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid  = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready  = 1'b1;
        end

        // AXI read channel
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rdata   = {24'h000000,
                             aic_rd(aic_axi_idx(s_axi_araddr), s_r.fault, status, s_r.ctrl)};
            s_nxt.rresp   = (aic_axi_idx(s_axi_araddr) == 8'h00) ? AIC_RESP_SLVERR
                                                                 : AIC_RESP_OKAY;
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid  = 1'b0;
            s_nxt.arready = 1'b1;
        end

        if (!s_r.stby_s) begin
            // Shutdown holds the port idle and registers at default
            s_nxt.ready    = 1'b0;
            s_nxt.wake_cnt = '0;
            s_nxt.i2c_st   = AIC_IDLE;
            s_nxt.sda_oe   = 1'b0;
            s_nxt.ctrl     = AIC_CTRL_RESET;
            s_nxt.fault    = 8'h00;
            s_nxt.diag     = 4'h0;
        end else begin
            // Wake delay after shutdown release
            if (!s_r.ready) begin
                if (s_r.wake_cnt == AIC_WAKE_W'(WAKE_CYCLES - 1)) begin
                    s_nxt.ready = 1'b1;
                end else begin
                    s_nxt.wake_cnt = s_r.wake_cnt + AIC_WAKE_W'(1);
                end
            end

            // Diagnostic results, cleared when a new run starts
            if (s_r.mon_s.diag_running) begin
                s_nxt.diag = 4'h0;
            end else if (s_r.mon_s.diag_done) begin
                s_nxt.diag = {s_r.mon_s.shorted_load, s_r.mon_s.open_load,
                              s_r.mon_s.short_ground,
                              s_r.mon_s.short_power_stage_supply};
            end

            // Serial slave, sampled on rise, driven on fall only
            if (!s_r.ready) begin
                s_nxt.i2c_st = AIC_IDLE;
                s_nxt.sda_oe = 1'b0;
            end else if (bus_start) begin
                s_nxt.i2c_st = AIC_RX;
                s_nxt.kind   = AIC_K_ADDR;
                s_nxt.cnt    = 4'h0;
                s_nxt.sda_oe = 1'b0;
            end else if (bus_stop) begin
                s_nxt.i2c_st = AIC_IDLE;
                s_nxt.sda_oe = 1'b0;
            end else begin
                case (s_r.i2c_st)
                    AIC_RX: begin
                        if (scl_rise) begin
                            s_nxt.sh  = {s_r.sh[6:0], s_r.sda_s};
                            s_nxt.cnt = s_r.cnt + 4'h1;
                        end else if (scl_fall && s_r.cnt == 4'h8) begin
                            s_nxt.cnt = 4'h0;
                            case (s_r.kind)
                                AIC_K_ADDR: begin
                                    if (s_r.sh[7:1] == AIC_SLAVE_ADDR) begin
                                        s_nxt.rw     = s_r.sh[0];
                                        s_nxt.sda_oe = 1'b1;
                                        s_nxt.i2c_st = AIC_ACK;
                                    end else begin
                                        s_nxt.i2c_st = AIC_IGNORE;
                                    end
                                end
                                AIC_K_INDEX: begin
                                    s_nxt.idx    = s_r.sh;
                                    s_nxt.sda_oe = 1'b1;
                                    s_nxt.i2c_st = AIC_ACK;
                                end
                                default: begin
                                    if (s_r.idx == AIC_IDX_CTRL) begin
                                        s_nxt.ctrl = s_r.sh;
                                    end
                                    s_nxt.idx    = s_r.idx + 8'h01;
                                    s_nxt.sda_oe = 1'b1;
                                    s_nxt.i2c_st = AIC_ACK;
                                end
                            endcase
                        end
                    end
                    AIC_ACK: begin
                        if (scl_fall) begin
                            if (s_r.kind == AIC_K_ADDR && s_r.rw) begin
                                s_nxt.sh     = aic_rd(s_r.idx, s_r.fault, status, s_r.ctrl);
                                s_nxt.sda_oe = ~s_nxt.sh[7];
                                s_nxt.i2c_st = AIC_TX;
                                clr          = (s_r.idx == AIC_IDX_FAULT);
                            end else begin
                                s_nxt.sda_oe = 1'b0;
                                s_nxt.i2c_st = AIC_RX;
                                s_nxt.kind   = (s_r.kind == AIC_K_ADDR) ? AIC_K_INDEX
                                                                        : AIC_K_DATA;
                            end
                        end
                    end
                    AIC_TX: begin
                        if (scl_rise) begin
                            s_nxt.cnt = s_r.cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (s_r.cnt == 4'h8) begin
                                s_nxt.cnt    = 4'h0;
                                s_nxt.sda_oe = 1'b0;
                                s_nxt.i2c_st = AIC_MACK;
                            end else begin
                                s_nxt.sh     = {s_r.sh[6:0], 1'b0};
                                s_nxt.sda_oe = ~s_r.sh[6];
                            end
                        end
                    end
                    AIC_MACK: begin
                        if (scl_rise) begin
                            s_nxt.mack = ~s_r.sda_s;
                        end else if (scl_fall) begin
                            if (s_r.mack) begin
                                nidx         = s_r.idx + 8'h01;
                                s_nxt.idx    = nidx;
                                s_nxt.sh     = aic_rd(nidx, s_r.fault, status, s_r.ctrl);
                                s_nxt.sda_oe = ~s_nxt.sh[7];
                                s_nxt.i2c_st = AIC_TX;
                                clr          = (nidx == AIC_IDX_FAULT);
                            end else begin
                                s_nxt.i2c_st = AIC_IGNORE;
                            end
                        end
                    end
                    default: begin
                        s_nxt.sda_oe = 1'b0;
                    end
                endcase
            end

            // Latched faults clear on serial read, a new event wins
            s_nxt.fault = (clr ? 8'h00 : s_r.fault) | live_flt;
        end

        // Pin and power-stage outputs
        s_nxt.alarm_oe        = s_r.stby_s && (|live_flt);
        s_nxt.amp.gain        = s_r.ctrl[AIC_CTRL_GAIN_HI:AIC_CTRL_GAIN_LO];
        s_nxt.amp.limit       = s_r.ctrl[AIC_CTRL_LIM_HI:AIC_CTRL_LIM_LO];
        s_nxt.amp.freq_500k   = s_r.ctrl[AIC_CTRL_FREQ];
        s_nxt.amp.play        = s_r.stby_s && !s_r.sil_s && !(|live_flt)
                                && !s_r.mon_s.diag_running;
        s_nxt.amp.outputs_hiz = !s_nxt.amp.play;
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r           <= '0;
            s_r.ctrl      <= AIC_CTRL_RESET;
            s_r.amp.gain  <= AIC_CTRL_RESET[AIC_CTRL_GAIN_HI:AIC_CTRL_GAIN_LO];
            s_r.amp.limit <= AIC_CTRL_RESET[AIC_CTRL_LIM_HI:AIC_CTRL_LIM_LO];
            s_r.amp.outputs_hiz <= 1'b1;
            s_r.awready   <= 1'b1;
            s_r.wready    <= 1'b1;
            s_r.arready   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs, open-drain pins only ever pull low
    assign sda_out       = 1'b0;
    assign sda_oe        = s_r.sda_oe;
    assign alarm_n_out   = 1'b0;
    assign alarm_n_oe    = s_r.alarm_oe;
    assign amp           = s_r.amp;
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready  = s_r.wready;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign s_axi_rvalid  = s_r.rvalid;

endmodule : aic_ctrl_slave

//--- aic_i2c_mstr.sv
// Purpose: Serial bus master model driving the control slave
// Assumes: Pull-up on both lines, link clock period of 80 ns
// Notes:   Clock stands still high between frames
module aic_i2c_mstr (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    // Bus idle, both lines released
    initial scl = 1'b1;
    initial sda_low = 1'b0;
    // One link clock: data set in low phase, sampled late in high phase
    task automatic clk_bit(input logic b, output logic v);
        #18 sda_low = !b;
        #20 scl = 1'b1;
        #37 v = sda;
        #3 scl = 1'b0;
        #2;
    endtask : clk_bit
    // Start or repeated start: data falls while clock high
    task automatic start();
        #18 sda_low = 1'b0;
        #20 scl = 1'b1;
        #20 sda_low = 1'b1;
        #20 scl = 1'b0;
        #2;
    endtask : start
    // Stop: data rises while clock high
    task automatic stop();
        #18 sda_low = 1'b1;
        #20 scl = 1'b1;
        #20 sda_low = 1'b0;
        #22;
    endtask : stop
    // Byte MSB first, then ninth clock; a low sends an acknowledge
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic ai);
        for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
        clk_bit(a, ai);
    endtask : xfer
endmodule : aic_i2c_mstr

//--- aic_chk_sva.sv
// Purpose: Concurrent checks on pins, mode outputs and read channel
// Assumes: Pins pass two sync flops, outputs registered behind them
// Notes:   Bound to every instance of the control slave
module aic_chk
    import aic_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        scl_in,
    input wire logic        standby_n,
    input wire logic        silence,
    input wire logic        sda_oe,
    input wire logic        alarm_n_oe,
    input wire aic_mon_s    monitor,
    input wire aic_amp_s    amp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [31:0] s_axi_rdata
);
    // Live faults that force the outputs to high impedance
    wire logic hz = |{monitor[10:6], monitor[3:2], monitor[0]};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Shutdown seen long enough to pass sync and register stages
    sequence s_off;
        (!standby_n)[*6];
    endsequence
    sequence s_read;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_OFF_SDA: assert property (s_off |-> !sda_oe)
        else $error("data line held in shutdown");
    AST_OFF_ALM: assert property (s_off |-> !alarm_n_oe)
        else $error("alarm driven in shutdown");
    AST_OFF_AMP: assert property (s_off |-> amp.gain == 2'h1 && amp.limit == 3'h7)
        else $error("settings not back to defaults");
    AST_HIZ: assert property (hz[*5] |-> amp.outputs_hiz && !amp.play)
        else $error("outputs live during fault");
    AST_MUTE: assert property (silence[*5] |-> !amp.play)
        else $error("playing while silenced");
    AST_ALM_SRC: assert property ((!hz)[*5] |-> !alarm_n_oe)
        else $error("alarm without live fault");
    AST_SCL_HI: assert property (scl_in[*4] |-> $stable(sda_oe))
        else $error("data changed while clock high");
    AST_RLAT: assert property (s_read |=> s_axi_rvalid)
        else $error("read answer late");
    AST_RERR: assert property (s_axi_rvalid && s_axi_rresp == AIC_RESP_SLVERR
                               |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
endmodule : aic_chk
bind aic_ctrl_slave aic_chk u_chk (.*);

//--- tb_amp_i2c_control_slave.sv
// Purpose: Self-checking bench for the amplifier control slave
// Assumes: Short wake count, serial traffic from the master model
// Notes:   Registers reached over AXI4-Lite, xorshift stimulus
module tb_amp_i2c_control_slave import aic_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned WAKE = 20;
    localparam logic [7:0]  WR = {AIC_SLAVE_ADDR, 1'b0};
    localparam logic [7:0]  RD = {AIC_SLAVE_ADDR, 1'b1};
    logic        clk = 1'b0, reset_n = 1'b0, standby_n = 1'b0, silence = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0, a, scl, m_low, sda_oe, alarm_n_oe;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v, q;
    logic [31:0] s_axi_wdata = 32'h0, r, seed = 32'h0001427C, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    aic_mon_s    monitor = '0;
    aic_amp_s    amp;
    wire logic   sda = !(m_low || sda_oe);
    int          err_count = 0, checks_done = 0;
    aic_ctrl_slave #(.WAKE_CYCLES(WAKE)) u_dut (.*, .scl_in(scl), .sda_in(sda), .sda_out(),
                                              .alarm_n_out());
    aic_i2c_mstr u_m (.scl(scl), .sda_low(m_low), .sda(sda));
    initial forever #5 clk = !clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("BAD %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task automatic give_verdict();
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    // Bus write, each channel held until its own ready
    task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        @(posedge clk);
    endtask : axw
    // Bus read and compare of data and response
    task automatic axc(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
        @(posedge clk);
    endtask : axc
    // Serial write of address, index and data, acknowledge level expected
    task automatic swr(input logic [7:0] ad, input logic [7:0] ix, input logic [7:0] d,
                       input logic ea);
        u_m.start();
        u_m.xfer(ad, 1'b1, q, a);
        chk(a, ea);
        u_m.xfer(ix, 1'b1, q, a);
        chk(a, ea);
        u_m.xfer(d, 1'b1, q, a);
        chk(a, ea);
        u_m.stop();
        @(posedge clk);
    endtask : swr
    initial begin
        #500000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        standby_n <= 1'b1;
        @(posedge clk);
        swr(WR, AIC_IDX_CTRL, 8'h00, 1'b1);
        axc(AIC_AXI_CTRL, AIC_CTRL_RESET, AIC_RESP_OKAY);
        // Every gain and limit code, random frequency bit
        for (int i = 0; i < 8; i++) begin
            r = xs();
            v = {i[1:0], i[2:0], 2'b00, r[0]};
            swr(WR, AIC_IDX_CTRL, v, 1'b0);
            axc(AIC_AXI_CTRL, v, AIC_RESP_OKAY);
            chk(amp, {v[7:3], v[0], 2'b10});
        end
        swr({AIC_SLAVE_ADDR ^ 7'h01, 1'b0}, AIC_IDX_CTRL, 8'h00, 1'b1);
        swr(WR, AIC_IDX_FAULT, 8'hFF, 1'b0);
        axc(AIC_AXI_CTRL, v, AIC_RESP_OKAY);
        r = xs();
        axw(AIC_AXI_CTRL, r, AIC_RESP_OKAY);
        axw(AIC_AXI_FAULT, 32'hFF, AIC_RESP_OKAY);
        axw(8'h20, r, AIC_RESP_SLVERR);
        axc(8'h20, 32'h0, AIC_RESP_SLVERR);
        axc(AIC_AXI_FAULT, 32'h0, AIC_RESP_OKAY);
        // Overheat pulse, then open load result from a diagnostic run
        monitor.die_overheat_shutdown <= 1'b1;
        repeat (6) @(posedge clk);
        chk(alarm_n_oe, 1'b1);
        monitor.die_overheat_shutdown <= 1'b0;
        monitor.open_load <= 1'b1;
        monitor.diag_done <= 1'b1;
        repeat (6) @(posedge clk);
        chk(alarm_n_oe, 1'b0);
        monitor.diag_done <= 1'b0;
        axc(AIC_AXI_FAULT, 32'h80, AIC_RESP_OKAY);
        // Sequential read from the fault register onwards
        u_m.start();
        u_m.xfer(WR, 1'b1, q, a);
        u_m.xfer(AIC_IDX_FAULT, 1'b1, q, a);
        u_m.start();
        u_m.xfer(RD, 1'b1, q, a);
        chk(a, 1'b0);
        u_m.xfer(8'hFF, 1'b0, q, a);
        chk(q, 8'h80);
        u_m.xfer(8'hFF, 1'b0, q, a);
        chk(q, 8'h84);
        u_m.xfer(8'hFF, 1'b1, q, a);
        chk(q, r[7:0]);
        u_m.stop();
        @(posedge clk);
        axc(AIC_AXI_FAULT, 32'h0, AIC_RESP_OKAY);
        monitor.diag_running <= 1'b1;
        repeat (6) @(posedge clk);
        axc(AIC_AXI_STATUS, 32'h20, AIC_RESP_OKAY);
        monitor.diag_running <= 1'b0;
        silence <= 1'b1;
        repeat (6) @(posedge clk);
        axc(AIC_AXI_STATUS, 32'h40, AIC_RESP_OKAY);
        silence <= 1'b0;
        repeat (6) @(posedge clk);
        chk(amp.play, 1'b1);
        // Shutdown with silence kept low
        standby_n <= 1'b0;
        repeat (6) @(posedge clk);
        axc(AIC_AXI_CTRL, AIC_CTRL_RESET, AIC_RESP_OKAY);
        swr(WR, AIC_IDX_CTRL, 8'h00, 1'b1);
        give_verdict();
    end
endmodule : tb_amp_i2c_control_slave
